// File: include/img_pkg.sv
// package: register map, field positions and carrier types of the interrupt mask block
package img_pkg;

  // register offsets (register index; byte address is four times the index)
  localparam logic [5:0] IMG_STATUS_IDX = 6'h05;
  localparam logic [5:0] IMG_MASK_IDX = 6'h04;
  localparam logic [5:0] IMG_SWRST_IDX = 6'h00;

  localparam int IMG_NUM_SRC = 16;
  localparam logic [15:0] IMG_MASK_RST = 16'h0000;
  localparam logic [15:0] IMG_STATUS_RST = 16'h0000;
  localparam logic [15:0] IMG_LIVE_BITS = 16'h7FFF;

  // field positions, shared by mask and status
  localparam int IMG_BIT_BUS_RETRY = 14;
  localparam int IMG_BIT_HEARTBEAT = 13;
  localparam int IMG_BIT_ADDR_TBL = 12;
  localparam int IMG_BIT_PROG = 11;
  localparam int IMG_BIT_RX_PKT = 10;
  localparam int IMG_BIT_TX_DONE = 9;
  localparam int IMG_BIT_TX_ERR = 8;
  localparam int IMG_BIT_TIMER = 7;
  localparam int IMG_BIT_RX_DESC = 6;
  localparam int IMG_BIT_RX_RSRC = 5;
  localparam int IMG_BIT_RX_AREA = 4;
  localparam int IMG_BIT_CHK_TALLY = 3;
  localparam int IMG_BIT_ALN_TALLY = 2;
  localparam int IMG_BIT_MISS_TALLY = 1;
  localparam int IMG_BIT_RX_OVR = 0;

  // software reset command bit in the control word
  localparam int IMG_BIT_SWRST = 7;

  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } img_bus_s;

  typedef struct packed {
    logic bus_retry;
    logic heartbeat_loss;
    logic addr_table_load_done;
    logic descriptor_irq_flag;
    logic rx_packet;
    logic tx_complete;
    logic tx_error;
    logic timer_wrap;
    logic rx_desc_empty;
    logic rx_resource_empty;
    logic rx_area_overflow;
    logic checksum_tally_wrap;
    logic alignment_tally_wrap;
    logic missed_tally_wrap;
    logic rx_fifo_overrun;
  } img_events_s;

endpackage : img_pkg

// File: rtl/img_flag.sv
// one sticky status flag with write-one-to-clear and set priority
`timescale 1ns/1ps
module img_flag (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_flag
);

  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (i_clr) begin
      flag_d = 1'b0;
    end
    // an event landing on the clear cycle must survive
    if (i_set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule : img_flag

// File: rtl/img_top.sv
// interrupt mask gating: enable mask, sticky status flags and the interrupt output
`timescale 1ns/1ps
module img_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire img_pkg::img_events_s i_events,
  output logic [15:0] o_rdata,
  output logic o_irq,
  output logic o_soft_reset
);

  img_pkg::img_bus_s bus;
  logic [15:0] evt_vec;
  logic [15:0] clr_vec;
  logic [15:0] status;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic soft_q;
  logic soft_d;
  logic wr_mask_hit;
  logic wr_status_hit;
  logic wr_swrst_hit;
  logic [15:0] mask_word;
  logic [15:0] status_word;

  // named views of the enable bits
  logic bus_retry_irq_on;
  logic heartbeat_loss_irq_on;
  logic addr_table_load_done_irq_on;
  logic programmed_irq_on;
  logic rx_packet_irq_on;
  logic tx_complete_irq_on;
  logic tx_error_irq_on;
  logic timer_wrap_irq_on;
  logic rx_desc_empty_irq_on;
  logic rx_resource_empty_irq_on;
  logic rx_area_overflow_irq_on;
  logic checksum_tally_wrap_irq_on;
  logic alignment_tally_wrap_irq_on;
  logic missed_tally_wrap_irq_on;
  logic rx_fifo_overrun_irq_on;

  // named views of the status flags
  logic bus_retry_flag;
  logic heartbeat_loss_flag;
  logic addr_table_load_done_flag;
  logic descriptor_irq_flag;
  logic rx_packet_flag;
  logic tx_complete_flag;
  logic tx_error_flag;
  logic timer_wrap_flag;
  logic rx_desc_empty_flag;
  logic rx_resource_empty_flag;
  logic rx_area_overflow_flag;
  logic checksum_tally_wrap_flag;
  logic alignment_tally_wrap_flag;
  logic missed_tally_wrap_flag;
  logic rx_fifo_overrun_flag;

  // per-source requests, each flag gated by its own enable
  logic bus_retry_req;
  logic heartbeat_loss_req;
  logic addr_table_load_done_req;
  logic programmed_req;
  logic rx_packet_req;
  logic tx_complete_req;
  logic tx_error_req;
  logic timer_wrap_req;
  logic rx_desc_empty_req;
  logic rx_resource_empty_req;
  logic rx_area_overflow_req;
  logic checksum_tally_wrap_req;
  logic alignment_tally_wrap_req;
  logic missed_tally_wrap_req;
  logic rx_fifo_overrun_req;

  assign bus.addr = i_addr;
  assign bus.wdata = i_wdata;
  assign bus.wr = i_wr;
  assign bus.rd = i_rd;

  // one decode per write target keeps the three write paths from drifting apart
  assign wr_mask_hit = bus.wr && bus.addr == img_pkg::IMG_MASK_IDX;
  assign wr_status_hit = bus.wr && bus.addr == img_pkg::IMG_STATUS_IDX;
  assign wr_swrst_hit = bus.wr && bus.addr == img_pkg::IMG_SWRST_IDX;

  // events come from logic on this clock, so they need no synchroniser
  always_comb begin
    evt_vec = 16'h0000;
    evt_vec[img_pkg::IMG_BIT_BUS_RETRY] = i_events.bus_retry;
    evt_vec[img_pkg::IMG_BIT_HEARTBEAT] = i_events.heartbeat_loss;
    evt_vec[img_pkg::IMG_BIT_ADDR_TBL] = i_events.addr_table_load_done;
    evt_vec[img_pkg::IMG_BIT_PROG] = i_events.descriptor_irq_flag;
    evt_vec[img_pkg::IMG_BIT_RX_PKT] = i_events.rx_packet;
    evt_vec[img_pkg::IMG_BIT_TX_DONE] = i_events.tx_complete;
    evt_vec[img_pkg::IMG_BIT_TX_ERR] = i_events.tx_error;
    evt_vec[img_pkg::IMG_BIT_TIMER] = i_events.timer_wrap;
    evt_vec[img_pkg::IMG_BIT_RX_DESC] = i_events.rx_desc_empty;
    evt_vec[img_pkg::IMG_BIT_RX_RSRC] = i_events.rx_resource_empty;
    evt_vec[img_pkg::IMG_BIT_RX_AREA] = i_events.rx_area_overflow;
    evt_vec[img_pkg::IMG_BIT_CHK_TALLY] = i_events.checksum_tally_wrap;
    evt_vec[img_pkg::IMG_BIT_ALN_TALLY] = i_events.alignment_tally_wrap;
    evt_vec[img_pkg::IMG_BIT_MISS_TALLY] = i_events.missed_tally_wrap;
    evt_vec[img_pkg::IMG_BIT_RX_OVR] = i_events.rx_fifo_overrun;
  end

  // write one clears; a zero bit leaves the flag alone
  always_comb begin
    clr_vec = 16'h0000;
    if (wr_status_hit) begin
      clr_vec = bus.wdata & img_pkg::IMG_LIVE_BITS;
    end
  end

  // software reset does not reach the flags, only the hardware reset does
  genvar g;
  generate
    for (g = 0; g < img_pkg::IMG_NUM_SRC; g++) begin : g_flag
      img_flag u_flag (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(evt_vec[g]),
        .i_clr(clr_vec[g]),
        .o_flag(status[g])
      );
    end
  endgenerate

  // bit 15 has a flag cell but no event, so it can never set
  assign bus_retry_flag = status[img_pkg::IMG_BIT_BUS_RETRY];
  assign heartbeat_loss_flag = status[img_pkg::IMG_BIT_HEARTBEAT];
  assign addr_table_load_done_flag = status[img_pkg::IMG_BIT_ADDR_TBL];
  assign descriptor_irq_flag = status[img_pkg::IMG_BIT_PROG];
  assign rx_packet_flag = status[img_pkg::IMG_BIT_RX_PKT];
  assign tx_complete_flag = status[img_pkg::IMG_BIT_TX_DONE];
  assign tx_error_flag = status[img_pkg::IMG_BIT_TX_ERR];
  assign timer_wrap_flag = status[img_pkg::IMG_BIT_TIMER];
  assign rx_desc_empty_flag = status[img_pkg::IMG_BIT_RX_DESC];
  assign rx_resource_empty_flag = status[img_pkg::IMG_BIT_RX_RSRC];
  assign rx_area_overflow_flag = status[img_pkg::IMG_BIT_RX_AREA];
  assign checksum_tally_wrap_flag = status[img_pkg::IMG_BIT_CHK_TALLY];
  assign alignment_tally_wrap_flag = status[img_pkg::IMG_BIT_ALN_TALLY];
  assign missed_tally_wrap_flag = status[img_pkg::IMG_BIT_MISS_TALLY];
  assign rx_fifo_overrun_flag = status[img_pkg::IMG_BIT_RX_OVR];

  // mask: bit 15 is cleared on every write and by reset, so it always reads zero
  always_comb begin
    mask_d = mask_q;
    if (wr_mask_hit) begin
      mask_d = bus.wdata & img_pkg::IMG_LIVE_BITS;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mask_q <= img_pkg::IMG_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // one enable bit per source
  assign bus_retry_irq_on = mask_q[img_pkg::IMG_BIT_BUS_RETRY];
  assign heartbeat_loss_irq_on = mask_q[img_pkg::IMG_BIT_HEARTBEAT];
  assign addr_table_load_done_irq_on = mask_q[img_pkg::IMG_BIT_ADDR_TBL];
  assign programmed_irq_on = mask_q[img_pkg::IMG_BIT_PROG];
  assign rx_packet_irq_on = mask_q[img_pkg::IMG_BIT_RX_PKT];
  assign tx_complete_irq_on = mask_q[img_pkg::IMG_BIT_TX_DONE];
  assign tx_error_irq_on = mask_q[img_pkg::IMG_BIT_TX_ERR];
  assign timer_wrap_irq_on = mask_q[img_pkg::IMG_BIT_TIMER];
  assign rx_desc_empty_irq_on = mask_q[img_pkg::IMG_BIT_RX_DESC];
  assign rx_resource_empty_irq_on = mask_q[img_pkg::IMG_BIT_RX_RSRC];
  assign rx_area_overflow_irq_on = mask_q[img_pkg::IMG_BIT_RX_AREA];
  assign checksum_tally_wrap_irq_on = mask_q[img_pkg::IMG_BIT_CHK_TALLY];
  assign alignment_tally_wrap_irq_on = mask_q[img_pkg::IMG_BIT_ALN_TALLY];
  assign missed_tally_wrap_irq_on = mask_q[img_pkg::IMG_BIT_MISS_TALLY];
  assign rx_fifo_overrun_irq_on = mask_q[img_pkg::IMG_BIT_RX_OVR];

  // a source reaches the output only through its own enable
  assign bus_retry_req = bus_retry_flag & bus_retry_irq_on;
  assign heartbeat_loss_req = heartbeat_loss_flag & heartbeat_loss_irq_on;
  assign addr_table_load_done_req = addr_table_load_done_flag & addr_table_load_done_irq_on;
  assign programmed_req = descriptor_irq_flag & programmed_irq_on;
  assign rx_packet_req = rx_packet_flag & rx_packet_irq_on;
  assign tx_complete_req = tx_complete_flag & tx_complete_irq_on;
  assign tx_error_req = tx_error_flag & tx_error_irq_on;
  assign timer_wrap_req = timer_wrap_flag & timer_wrap_irq_on;
  assign rx_desc_empty_req = rx_desc_empty_flag & rx_desc_empty_irq_on;
  assign rx_resource_empty_req = rx_resource_empty_flag & rx_resource_empty_irq_on;
  assign rx_area_overflow_req = rx_area_overflow_flag & rx_area_overflow_irq_on;
  assign checksum_tally_wrap_req = checksum_tally_wrap_flag & checksum_tally_wrap_irq_on;
  assign alignment_tally_wrap_req = alignment_tally_wrap_flag & alignment_tally_wrap_irq_on;
  assign missed_tally_wrap_req = missed_tally_wrap_flag & missed_tally_wrap_irq_on;
  assign rx_fifo_overrun_req = rx_fifo_overrun_flag & rx_fifo_overrun_irq_on;

  // gate each flag with its enable; recomputed every cycle
  // the output is registered, so it lags the flag by one cycle
  always_comb begin
    // a held event level re-sets its flag every cycle, so a clear only sticks once it drops
    irq_d = bus_retry_req |
      heartbeat_loss_req |
      addr_table_load_done_req |
      programmed_req |
      rx_packet_req |
      tx_complete_req |
      tx_error_req |
      timer_wrap_req |
      rx_desc_empty_req |
      rx_resource_empty_req |
      rx_area_overflow_req |
      checksum_tally_wrap_req |
      alignment_tally_wrap_req |
      missed_tally_wrap_req |
      rx_fifo_overrun_req;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // software reset pulse, one cycle per write of the command bit
  always_comb begin
    soft_d = 1'b0;
    if (wr_swrst_hit) begin
      soft_d = bus.wdata[img_pkg::IMG_BIT_SWRST];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= soft_d;
    end
  end

  // read words rebuilt from the named bits; the spare top bit is a hard zero
  assign mask_word = {
    1'b0,
    bus_retry_irq_on,
    heartbeat_loss_irq_on,
    addr_table_load_done_irq_on,
    programmed_irq_on,
    rx_packet_irq_on,
    tx_complete_irq_on,
    tx_error_irq_on,
    timer_wrap_irq_on,
    rx_desc_empty_irq_on,
    rx_resource_empty_irq_on,
    rx_area_overflow_irq_on,
    checksum_tally_wrap_irq_on,
    alignment_tally_wrap_irq_on,
    missed_tally_wrap_irq_on,
    rx_fifo_overrun_irq_on
  };

  assign status_word = {
    1'b0,
    bus_retry_flag,
    heartbeat_loss_flag,
    addr_table_load_done_flag,
    descriptor_irq_flag,
    rx_packet_flag,
    tx_complete_flag,
    tx_error_flag,
    timer_wrap_flag,
    rx_desc_empty_flag,
    rx_resource_empty_flag,
    rx_area_overflow_flag,
    checksum_tally_wrap_flag,
    alignment_tally_wrap_flag,
    missed_tally_wrap_flag,
    rx_fifo_overrun_flag
  };

  // read data stand only in the cycle after the read strobe; unmapped reads zero
  always_comb begin
    rdata_d = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        img_pkg::IMG_MASK_IDX: begin
          rdata_d = mask_word;
        end
        img_pkg::IMG_STATUS_IDX: begin
          rdata_d = status_word;
        end
        // an unmapped index is not an error, it just reads zero
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_soft_reset = soft_q;

endmodule : img_top

// File: sim/img_top_asserts.sv
// checker: port-level properties of the interrupt mask block
`timescale 1ns/1ps
module img_top_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire img_pkg::img_events_s i_events,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_soft_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_quiet_after_rst: assert property (!$past(i_rst_n) |-> !o_irq && o_rdata == 16'h0000)
    else $error("output active right after reset");
  a_mask_readback: assert property (i_wr && i_addr == img_pkg::IMG_MASK_IDX ##1 !i_wr ##1
    i_rd && i_addr == img_pkg::IMG_MASK_IDX |=> o_rdata == ($past(i_wdata, 3) & img_pkg::IMG_LIVE_BITS))
    else $error("mask read back differs from write");
  a_top_bit_zero: assert property ($past(i_rd) |-> !o_rdata[15])
    else $error("top read bit not zero");
  a_unmapped_zero: assert property (i_rd && !(i_addr inside {6'h00, 6'h04, 6'h05}) |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_flag_sticky: assert property ((i_events != 15'h0000) ##1 !i_wr ##1
    (i_rd && i_addr == img_pkg::IMG_STATUS_IDX) |=> (o_rdata[14:0] & $past(i_events, 3)) == $past(i_events, 3))
    else $error("status flag lost before read");
  a_irq_rise_cause: assert property ($rose(o_irq) |-> $past(i_events, 2) != 15'h0000 || $past(i_wr, 2))
    else $error("interrupt rose without cause");
  a_irq_fall_cause: assert property ($fell(o_irq) |-> $past(i_wr, 2))
    else $error("interrupt fell without write");
  a_masked_off: assert property (i_wr && i_addr == img_pkg::IMG_MASK_IDX && i_wdata == 16'h0000 |-> ##2 !o_irq)
    else $error("interrupt with empty mask");
  a_soft_cause: assert property (o_soft_reset |-> $past(i_wr) && $past(i_addr) == img_pkg::IMG_SWRST_IDX &&
    $past(i_wdata[img_pkg::IMG_BIT_SWRST]))
    else $error("software reset pulse without its write");
  c_irq: cover property (o_irq);
  c_irq_fall: cover property ($fell(o_irq));
  c_soft: cover property (o_soft_reset);
endmodule : img_top_asserts
bind img_top img_top_asserts u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_events(i_events), .o_rdata(o_rdata), .o_irq(o_irq), .o_soft_reset(o_soft_reset));

// File: sim/img_top_tb.sv
// testbench: register and interrupt sequences for the interrupt mask block
`timescale 1ns/1ps
module img_top_tb;
  localparam logic [5:0] msk = img_pkg::IMG_MASK_IDX;
  localparam logic [5:0] sts = img_pkg::IMG_STATUS_IDX;
  logic i_clk, i_rst_n, i_wr, i_rd, o_irq, o_soft_reset;
  logic [5:0] i_addr;
  logic [15:0] i_wdata, o_rdata;
  img_pkg::img_events_s i_events;
  int num_errors = 0;
  int checks_done = 0;
  int k;
  img_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_events(i_events), .o_rdata(o_rdata), .o_irq(o_irq), .o_soft_reset(o_soft_reset));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task results;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %0s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task step;
    @(posedge i_clk);
    #1;
  endtask : step
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", e, o_rdata);
  endtask : rd
  task ev(input logic [15:0] v);
    @(posedge i_clk);
    i_events <= img_pkg::img_events_s'(v[14:0]);
    @(posedge i_clk);
    i_events <= '0;
  endtask : ev
  // interrupt is registered behind the flag, so look one edge later
  task irq(input logic e);
    step;
    chk("irq", {15'h0000, e}, {15'h0000, o_irq});
  endtask : irq
  task rst;
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(msk, 16'h0000);
    rd(sts, 16'h0000);
    irq(1'b0);
    $display("test reset done");
  endtask : rst
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    results;
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    i_events = '0;
    rst;
    wr(msk, 16'hFFFF);
    rd(msk, 16'h7FFF);
    rd(6'h3F, 16'h0000);
    $display("test mask access done");
    for (k = 0; k < 15; k++) begin
      wr(msk, 16'h0001 << k);
      ev(16'h0001 << ((k + 1) % 15));
      irq(1'b0);
      ev(16'h0001 << k);
      irq(1'b1);
      wr(sts, 16'h0000);
      irq(1'b1);
      rd(sts, (16'h0001 << k) | (16'h0001 << ((k + 1) % 15)));
      wr(sts, 16'h0001 << k);
      irq(1'b0);
      wr(sts, 16'h7FFF);
    end
    $display("test per source done");
    wr(msk, 16'h0000);
    ev(16'h7FFF);
    rd(sts, 16'h7FFF);
    irq(1'b0);
    wr(msk, 16'h8000);
    irq(1'b0);
    wr(msk, 16'h0001);
    irq(1'b1);
    wr(img_pkg::IMG_SWRST_IDX, 16'h0080);
    #1;
    chk("soft_reset", 16'h0001, {15'h0000, o_soft_reset});
    step;
    chk("soft_reset", 16'h0000, {15'h0000, o_soft_reset});
    rd(sts, 16'h7FFF);
    rd(msk, 16'h0001);
    // an event on the clear cycle keeps its flag
    @(posedge i_clk);
    i_events <= img_pkg::img_events_s'(15'h0001);
    i_addr <= sts;
    i_wdata <= 16'h7FFF;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_events <= '0;
    i_wr <= 1'b0;
    rd(sts, 16'h0001);
    $display("test gating done");
    @(posedge i_clk);
    rst;
    results;
  end
endmodule : img_top_tb
